// >>> src/spdif_tx_pkg.sv
package spdif_tx_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map
    localparam logic [7:0] TX_CONTROL_ADDR = 8'h1e;   // Transmitter control
    localparam logic [7:0] POWER_CTRL_ADDR = 8'h33;   // Power-down control two
    localparam logic [7:0] CLOCK_CFG_ADDR = 8'h40;    // Clocking configuration

    // Transmitter control fields
    localparam int SRC_LSB = 0;
    localparam int CHST_OVW_BIT = 2;
    localparam int THROUGH_BIT = 3;
    localparam int VAL_OVW_BIT = 4;
    localparam int VAL_SF0_BIT = 5;
    localparam int VAL_SF1_BIT = 6;
    localparam logic [7:0] TX_CONTROL_MASK = 8'h7f;   // Bit 7 reserved, reads zero
    localparam logic [7:0] TX_CONTROL_RESET = 8'h00;

    // Power-down control field
    localparam int TX_PD_BIT = 4;
    localparam logic [7:0] POWER_CTRL_RESET = 8'h10;  // Transmitter starts disabled

    // Clocking configuration fields
    localparam int FREQ_RANGE_LSB = 0;
    localparam int POSTSCALE_BIT = 2;
    localparam int RX_ENABLE_BIT = 3;
    localparam int SYNC_MODE_BIT = 4;
    localparam logic [7:0] CLOCK_CFG_MASK = 8'h1f;
    localparam logic [7:0] CLOCK_CFG_RESET = 8'h00;
    localparam logic [7:0] HW_CLOCK_CFG = 8'h08;      // Receiver on, automatic PLL

    // Receiver rate modes and the matching 256fs PLL output settings
    localparam logic [1:0] RATE_MODE_96K = 2'h1;
    localparam logic [1:0] RATE_MODE_48K = 2'h2;
    localparam logic [1:0] RATE_MODE_32K = 2'h3;
    localparam logic [1:0] RANGE_96K = 2'h0;
    localparam logic [1:0] RANGE_48K = 2'h1;
    localparam logic [1:0] RANGE_32K = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame geometry and timing
    localparam logic [7:0] LAST_FRAME = 8'hbf;        // 192 frames per block
    localparam logic [7:0] CONSUMER_FRAMES = 8'h28;   // 40 frames carry status
    localparam logic [5:0] LAST_HALF_CELL = 6'h3f;    // 32 slots, two halves each
    localparam logic [4:0] FIRST_DATA_SLOT = 5'h04;
    localparam int HALF_CELL_DIV_DEFAULT = 8;

    // Preamble half-cell patterns, sent MSB first, for a preceding low level
    localparam logic [7:0] PRE_BLOCK = 8'he8;
    localparam logic [7:0] PRE_FIRST = 8'he2;
    localparam logic [7:0] PRE_SECOND = 8'he4;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {SRC_RECEIVER, SRC_ADC, SRC_SECONDARY, SRC_PRIMARY} tx_source_t;
    typedef enum logic {TX_OFF, TX_RUN} tx_state_t;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } stereo_sample_t;

    typedef struct packed {
        logic validity;
        logic user;
        logic chanStatus;
    } flag_bits_t;

    typedef struct packed {
        stereo_sample_t sample;
        flag_bits_t first;
        flag_bits_t second;
    } rx_frame_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// >>> src/spdif_transmitter_framer.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Hardware mode loads default clocking at reset
// - Hardware mode keeps master clock at 256fs
// - Runs synchronous or asynchronous to audio
// - Bi-phase-mark stream, two sub-frames per frame
// - Audio in slots 4 to 27, LSB first, 24 bits
// - Preamble starts sub-frame, marks block start
// - Validity one means invalid sample
// - Parity gives even parity excluding preamble
// - Block spans 192 frames of status bits
// - Consumer status only in first 40 frames
// - Two-bit select picks transmitted audio source
// - Status overwrite bit applies to receiver source
// - Through bit drives pin from input mux
// - Validity zero, or recovered for receiver source
// - Overwrite sets per-sub-frame validity from bits
// - Power-down bit disables transmitter, resets set
// - Transmitter builds preamble and parity bit itself
// - User bit zero unless receiver is source
module spdif_transmitter_framer
    import spdif_tx_pkg::*;
#(
    parameter int HALF_CELL_DIV = HALF_CELL_DIV_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire reg_req_t regReq,
    output logic [7:0] regRdata,
    input wire logic hwMode,
    input wire logic [1:0] rxRateMode,
    input wire rx_frame_t rxFrame,
    input wire stereo_sample_t adcFrame,
    input wire stereo_sample_t secondaryFrame,
    input wire stereo_sample_t primaryFrame,
    input wire logic [39:0] txChanStatus,
    input wire logic inputMuxLine,
    input wire logic audioHalfCellTick,
    output logic sampleTaken,
    output logic serial_audio_out_pin,
    output logic rxEnable,
    output logic [1:0] pll_freq_range_sel,
    output logic pll_output_divider
);

    localparam int DIV_W = (HALF_CELL_DIV > 1) ? $clog2(HALF_CELL_DIV) : 1;

    ////////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] txControl;        // Source, overwrite, through, validity
    logic [7:0] powerCtrl;        // Only the transmitter power-down bit lives here
    logic [7:0] clockCfg;         // PLL and mode control used outside hardware mode

    wire hitControl = regReq.addr == TX_CONTROL_ADDR;
    wire hitPower = regReq.addr == POWER_CTRL_ADDR;
    wire hitClock = regReq.addr == CLOCK_CFG_ADDR;

    // Writes; hardware mode locks clocking so software cannot disturb it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            txControl <= TX_CONTROL_RESET;
            powerCtrl <= POWER_CTRL_RESET;
            clockCfg <= hwMode ? HW_CLOCK_CFG : CLOCK_CFG_RESET;
        end else if (regReq.wr) begin
            if (hitControl) begin
                txControl <= regReq.wdata & TX_CONTROL_MASK;
            end
            if (hitPower) begin
                powerCtrl <= regReq.wdata & POWER_CTRL_RESET;
            end
            if (hitClock && !hwMode) begin
                clockCfg <= regReq.wdata & CLOCK_CFG_MASK;
            end
        end
    end

    // Read data in the cycle after the strobe; unmapped addresses read zero
    wire [7:0] readMux = hitControl ? txControl :
                         hitPower ? powerCtrl :
                         hitClock ? clockCfg : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= regReq.rd ? readMux : 8'h00;
        end
    end

    // Field decode
    wire tx_source_t txAudioSourceSel = tx_source_t'(txControl[SRC_LSB +: 2]);
    wire chanStatusOverwrite = txControl[CHST_OVW_BIT];
    wire throughMode = txControl[THROUGH_BIT];
    wire validityOverwriteEn = txControl[VAL_OVW_BIT];
    wire validityFirstSubframe = txControl[VAL_SF0_BIT];
    wire validitySecondSubframe = txControl[VAL_SF1_BIT];
    wire txPowerDown = powerCtrl[TX_PD_BIT];
    wire syncMode = clockCfg[SYNC_MODE_BIT];
    wire fromReceiver = txAudioSourceSel == SRC_RECEIVER;

    ////////////////////////////////////////////////////////////////////////////////
    // Clocking outputs
    // Maps the receiver's rate mode to a 256fs divider setting
    function automatic logic [1:0] range_for_rate(input logic [1:0] mode);
        case (mode)
            RATE_MODE_96K: range_for_rate = RANGE_96K;
            RATE_MODE_48K: range_for_rate = RANGE_48K;
            RATE_MODE_32K: range_for_rate = RANGE_32K;
            default: range_for_rate = RANGE_48K;   // Unlocked: hold the common rate
        endcase
    endfunction

    wire [1:0] autoRange = range_for_rate(rxRateMode);
    assign pll_freq_range_sel = hwMode ? autoRange : clockCfg[FREQ_RANGE_LSB +: 2];
    assign pll_output_divider = hwMode ? 1'b0 : clockCfg[POSTSCALE_BIT];
    assign rxEnable = hwMode | clockCfg[RX_ENABLE_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Half bit-cell rate
    // Async: free-running divider; sync: follow the audio clocks' own tick.
    // The divider costs accuracy against the real sample rate, traded for one clock.
    logic [DIV_W-1:0] divCount;
    wire divTick = divCount == DIV_W'(HALF_CELL_DIV - 1);
    wire cellTick = syncMode ? audioHalfCellTick : divTick;

    always_ff @(posedge ref_clk) begin
        if (rst || divTick) begin
            divCount <= '0;
        end else begin
            divCount <= divCount + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power state
    tx_state_t state;
    tx_state_t next_state;

    // Power-down holds the framer idle
    always_comb begin
        case (state)
            TX_OFF: next_state = txPowerDown ? TX_OFF : TX_RUN;
            TX_RUN: next_state = txPowerDown ? TX_OFF : TX_RUN;
            default: next_state = TX_OFF;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= TX_OFF;
        end else begin
            state <= next_state;
        end
    end

    wire running = state == TX_RUN;
    wire step = running && cellTick;

    ////////////////////////////////////////////////////////////////////////////////
    // Position counters
    logic [5:0] halfIdx;          // Slot in [5:1], half cell in [0]
    logic subIdx;                 // 0 first sub-frame, 1 second
    logic [7:0] frameIdx;         // Frame within the block
    wire [4:0] slot = halfIdx[5:1];
    wire subEnd = halfIdx == LAST_HALF_CELL;
    wire frameStart = step && halfIdx == 6'h00 && !subIdx;

    // Advance one half cell per tick; wrap sub-frame, frame and block
    always_ff @(posedge ref_clk) begin
        if (rst || !running) begin
            halfIdx <= 6'h00;
            subIdx <= 1'b0;
            frameIdx <= 8'h00;
        end else if (step) begin
            halfIdx <= halfIdx + 6'h01;
            if (subEnd) begin
                subIdx <= ~subIdx;
                if (subIdx) begin
                    frameIdx <= (frameIdx == LAST_FRAME) ? 8'h00 : frameIdx + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sample capture at the first half cell of each frame
    stereo_sample_t curSample;
    flag_bits_t rxFirst;
    flag_bits_t rxSecond;

    wire stereo_sample_t srcSample = (txAudioSourceSel == SRC_ADC) ? adcFrame :
                                     (txAudioSourceSel == SRC_SECONDARY) ? secondaryFrame :
                                     (txAudioSourceSel == SRC_PRIMARY) ? primaryFrame :
                                     rxFrame.sample;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            curSample <= '0;
            rxFirst <= '0;
            rxSecond <= '0;
            sampleTaken <= 1'b0;
        end else begin
            sampleTaken <= frameStart;
            if (frameStart) begin
                curSample <= srcSample;
                rxFirst <= rxFrame.first;
                rxSecond <= rxFrame.second;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sub-frame content
    wire [23:0] subSample = subIdx ? curSample.right : curSample.left;
    wire flag_bits_t rxFlags = subIdx ? rxSecond : rxFirst;
    wire overwriteBit = subIdx ? validitySecondSubframe : validityFirstSubframe;

    // Validity: overwrite, recovered, or valid
    wire validityBit = validityOverwriteEn ? overwriteBit :
                       fromReceiver ? rxFlags.validity : 1'b0;

    // User data only forwards what the receiver recovered
    wire userBit = fromReceiver ? rxFlags.user : 1'b0;

    // Status: recovered for receiver source unless overwritten; register bits only in the first 40 frames
    wire inConsumer = frameIdx < CONSUMER_FRAMES;
    wire regStatusBit = inConsumer ? txChanStatus[frameIdx[5:0]] : 1'b0;
    wire chanBit = (fromReceiver && !chanStatusOverwrite) ? rxFlags.chanStatus
                                                          : regStatusBit;

    // Even parity over slots 4 to 30
    wire parityBit = ^{subSample, validityBit, userBit, chanBit};

    // Slot layout, indexed by slot number
    wire [31:0] subWord = {parityBit, chanBit, userBit, validityBit,
                           subSample, 4'h0};
    wire dataBit = subWord[slot];

    // Preamble choice
    wire [7:0] preamble = subIdx ? PRE_SECOND :
                          (frameIdx == 8'h00) ? PRE_BLOCK : PRE_FIRST;

    ////////////////////////////////////////////////////////////////////////////////
    // Bi-phase-mark encoder
    logic lineLevel;              // Transmitter line level
    logic preBase;                // Level before the current preamble
    wire inPreamble = slot < FIRST_DATA_SLOT;
    wire baseLevel = (halfIdx == 6'h00) ? lineLevel : preBase;
    wire preLevel = preamble[3'h7 - halfIdx[2:0]] ^ baseLevel;
    wire cellLevel = halfIdx[0] ? (lineLevel ^ dataBit) : ~lineLevel;

    // Preambles are inverted when the line was high, so the pattern always
    // breaks the coding rule in the same way
    always_ff @(posedge ref_clk) begin
        if (rst || !running) begin
            lineLevel <= 1'b0;
            preBase <= 1'b0;
        end else if (step) begin
            if (halfIdx == 6'h00) begin
                preBase <= lineLevel;
            end
            lineLevel <= inPreamble ? preLevel : cellLevel;
        end
    end

    // Bypass takes the input mux straight to the pin, even when powered down
    assign serial_audio_out_pin = throughMode ? inputMuxLine :
                                  (running ? lineLevel : 1'b0);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    txoff_quiet_a: assert property (!throughMode && state == TX_OFF |-> !serial_audio_out_pin)
        else $error("Pin active while transmitter powered down");

    through_pin_a: assert property (throughMode |-> serial_audio_out_pin == inputMuxLine)
        else $error("Through mode does not follow input mux");

    cell_edge_a: assert property (step && !inPreamble && !halfIdx[0] && running ##1 running
                                  |-> lineLevel != $past(lineLevel))
        else $error("No transition at bit-cell boundary");

    parity_even_a: assert property (running && !inPreamble |-> ^subWord[31:4] == 1'b0)
        else $error("Sub-frame parity not even");

    validity_ovw_a: assert property (validityOverwriteEn && !subIdx
                                     |-> validityBit == validityFirstSubframe)
        else $error("Sub-frame 0 validity not from overwrite bit");

    validity_zero_a: assert property (!validityOverwriteEn && !fromReceiver
                                      |-> !validityBit)
        else $error("Validity not zero for local source");

    user_zero_a: assert property (!fromReceiver |-> !userBit)
        else $error("User bit set for local source");

    consumer_status_a: assert property (frameIdx >= CONSUMER_FRAMES
                                        && (!fromReceiver || chanStatusOverwrite)
                                        |-> !chanBit)
        else $error("Status bit set beyond consumer frames");

    block_wrap_a: assert property (step && subEnd && subIdx && frameIdx == LAST_FRAME
                                   && next_state == TX_RUN |=> frameIdx == 8'h00)
        else $error("Block does not wrap after 192 frames");

    hw_clock_a: assert property (hwMode && rxRateMode == RATE_MODE_96K
                                 |-> pll_freq_range_sel == RANGE_96K && rxEnable)
        else $error("Hardware mode clocking not automatic");

    block_start_c: cover property (frameStart && frameIdx == 8'h00);
    second_sub_c: cover property (step && subEnd && subIdx);
    through_c: cover property (throughMode && running);
    overwrite_c: cover property (fromReceiver && chanStatusOverwrite && step);

endmodule

// >>> tb/spdif_rx_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Far-end receiver: decodes the line from its edges alone
module spdif_rx_model
    import spdif_tx_pkg::*;
#(
    parameter int HALF = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic lineIn,
    output logic sfValid,
    output logic [1:0] sfPre,
    output logic [27:0] sfBits,
    output logic sfCodeErr
);
    logic lastLevel; // Level of the run in progress
    logic armed; // Inside a sub-frame
    int runCycles; // Cycles since the last edge
    int runLen; // Finished run, in half cells
    logic halves[$]; // Half-cell levels of this sub-frame
    logic [7:0] pre; // Preamble, first half normalised high
    logic [27:0] bits; // Slots 4 to 31
    logic err; // A cell boundary without a toggle

    ////////////////////////////////////////////////////////////////////////////////
    // Decode one sub-frame; preamble code 3 means no legal pattern
    task automatic decode();
        pre = '0;
        err = 1'b0;
        for (int i = 0; i < 8; i++) begin
            pre = {pre[6:0], halves[i] ^ ~halves[0]};
        end
        for (int s = 4; s < 32; s++) begin
            bits[s - 4] = halves[2 * s] ^ halves[2 * s + 1];
            err = err | (halves[2 * s] == halves[2 * s - 1]);
        end
        sfPre <= (pre == PRE_BLOCK) ? 2'd0 : (pre == PRE_FIRST) ? 2'd1 :
            (pre == PRE_SECOND) ? 2'd2 : 2'd3;
        sfBits <= bits;
        sfCodeErr <= err;
        sfValid <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Edges only, so the sender's tick phase never has to be known
    always @(posedge ref_clk) begin
        sfValid <= 1'b0;
        if (rst) begin
            lastLevel = 1'b0;
            armed = 1'b0;
            runCycles = 0;
            halves.delete();
        end else if (lineIn === lastLevel) begin
            runCycles++;
        end else begin
            runLen = (runCycles + 1 + HALF / 2) / HALF;
            // Three half cells occur only in a preamble
            if (runLen == 3 && (halves.size() == 0 || halves.size() >= 8)) begin
                armed = 1'b1;
                halves.delete();
            end else if (runLen < 1 || runLen > 3) begin
                armed = 1'b0; // Idle or broken line
            end
            if (armed) begin
                repeat (runLen) halves.push_back(lastLevel);
            end
            if (halves.size() >= 64) begin
                decode();
                halves.delete();
            end
            lastLevel = lineIn;
            runCycles = 0;
        end
    end
endmodule

// >>> tb/tb_spdif_transmitter_framer.sv
`timescale 1ns/1ps

module tb_spdif_transmitter_framer;
    import spdif_tx_pkg::*;
    logic ref_clk, rst, hwMode, inputMuxLine, audioHalfCellTick;
    reg_req_t regReq;
    logic [7:0] regRdata, ctrl, rdv;
    logic [1:0] rxRateMode, pll_freq_range_sel, gotPre;
    rx_frame_t rxFrame;
    stereo_sample_t adcFrame, secondaryFrame, primaryFrame;
    logic [39:0] txChanStatus;
    logic sampleTaken, serial_audio_out_pin, rxEnable, pll_output_divider;
    logic sfValid, sfCodeErr, started;
    logic [1:0] sfPre;
    logic [27:0] sfBits, gotBits;
    int fails, compares, cycles, frameIdx, w;
    logic [1:0] rangeExp [4] = '{RANGE_48K, RANGE_96K, RANGE_48K, RANGE_32K};

    ////////////////////////////////////////////////////////////////////////////////
    // Short divider keeps a whole block inside the run
    spdif_transmitter_framer #(.HALF_CELL_DIV(2)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .regReq(regReq), .regRdata(regRdata), .hwMode(hwMode), .rxRateMode(rxRateMode),
        .rxFrame(rxFrame), .adcFrame(adcFrame), .secondaryFrame(secondaryFrame),
        .primaryFrame(primaryFrame), .txChanStatus(txChanStatus), .inputMuxLine(inputMuxLine),
        .audioHalfCellTick(audioHalfCellTick), .sampleTaken(sampleTaken),
        .serial_audio_out_pin(serial_audio_out_pin), .rxEnable(rxEnable),
        .pll_freq_range_sel(pll_freq_range_sel), .pll_output_divider(pll_output_divider));
    spdif_rx_model #(.HALF(2)) u_rx (.ref_clk(ref_clk), .rst(rst),
        .lineIn(serial_audio_out_pin), .sfValid(sfValid), .sfPre(sfPre), .sfBits(sfBits),
        .sfCodeErr(sfCodeErr));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, sync-mode tick every other cycle, hang guard
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        audioHalfCellTick <= ~audioHalfCellTick;
        cycles++;
        if (cycles == 95000) begin
            fails++;
            $display("[FAIL] timeout expected done seen hang");
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare, bus cycles and closing report
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        regReq <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        regReq <= '{a, d, 1'b0, 1'b0};
        @(posedge ref_clk);
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        regReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        regReq <= '{a, 8'h00, 1'b0, 1'b0};
        #1 d = regRdata; // Stands only in this cycle
        @(posedge ref_clk);
    endtask
    task automatic test_done();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Expected slots 4 to 31 of one sub-frame
    function automatic logic [27:0] expect_sf(input logic sf, input logic [7:0] c, input int fr);
        logic [23:0] s;
        flag_bits_t f;
        logic [27:0] e;
        f = sf ? rxFrame.second : rxFrame.first;
        case (c[1:0])
            2'd0: s = sf ? rxFrame.sample.right : rxFrame.sample.left;
            2'd1: s = sf ? adcFrame.right : adcFrame.left;
            2'd2: s = sf ? secondaryFrame.right : secondaryFrame.left;
            default: s = sf ? primaryFrame.right : primaryFrame.left;
        endcase
        e[23:0] = s;
        e[24] = c[4] ? (sf ? c[6] : c[5]) : (c[1:0] == 2'd0 && f.validity);
        e[25] = c[1:0] == 2'd0 && f.user;
        e[26] = (c[1:0] == 2'd0 && !c[2]) ? f.chanStatus : (fr < 40 && txChanStatus[fr]);
        e[27] = ^e[26:0];
        return e;
    endfunction

    // Wait for a decoded sub-frame; frame count wraps at one block
    task automatic next_sf();
        int n;
        n = 0;
        @(posedge ref_clk);
        while (sfValid !== 1'b1 && n < 2000) begin
            @(posedge ref_clk);
            n++;
        end
        check("subframe seen", n < 2000, 1'b1);
        check("cell toggles", sfCodeErr, 1'b0);
        gotPre = sfPre;
        gotBits = sfBits;
        if (!gotPre[1]) begin
            frameIdx = started ? (frameIdx + 1) % 192 : 0;
            started = 1'b1;
        end
    endtask
    task automatic sf_checked();
        next_sf();
        check("preamble", gotPre, gotPre[1] ? 2'd2 : (frameIdx == 0 ? 2'd0 : 2'd1));
        check("slots", gotBits, expect_sf(gotPre[1], ctrl, frameIdx));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(47046));
        {fails, compares, cycles, frameIdx, started} = '0;
        {rst, hwMode, rxRateMode, inputMuxLine, audioHalfCellTick} = 6'h20;
        {regReq, rxFrame, adcFrame, secondaryFrame, primaryFrame, txChanStatus} = '0;
        ctrl = 8'h00;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        reg_rd(TX_CONTROL_ADDR, rdv);
        check("control reset", rdv, 8'h00);
        reg_rd(POWER_CTRL_ADDR, rdv);
        check("power reset", rdv, 8'h10);
        reg_rd(8'h55, rdv);
        check("unmapped read", rdv, 8'h00);
        reg_wr(TX_CONTROL_ADDR, 8'hff);
        reg_rd(TX_CONTROL_ADDR, rdv);
        check("control mask", rdv, 8'h7f);
        reg_wr(POWER_CTRL_ADDR, 8'h00);
        $display("test registers done");
        // Every source, random flags and overwrite bits, fresh samples each time
        for (int k = 0; k < 18; k++) begin
            ctrl = 8'($urandom) & 8'h77;
            ctrl[1:0] = k[1:0];
            rxFrame <= 54'({$urandom, $urandom});
            adcFrame <= 48'({$urandom, $urandom});
            secondaryFrame <= 48'({$urandom, $urandom});
            primaryFrame <= 48'({$urandom, $urandom});
            txChanStatus <= 40'({$urandom, $urandom});
            reg_wr(TX_CONTROL_ADDR, ctrl);
            w = 0;
            while (w < 2) begin
                next_sf();
                if (gotPre == 2'd2) w++;
            end
            repeat (4) sf_checked();
        end
        // Run on to the next block start
        do sf_checked(); while (gotPre != 2'd0);
        $display("test frames done");
        reg_wr(TX_CONTROL_ADDR, 8'h08);
        repeat (8) begin
            @(posedge ref_clk);
            inputMuxLine <= 1'($urandom);
            #1 check("through pin", serial_audio_out_pin, inputMuxLine);
        end
        @(posedge ref_clk);
        ctrl = 8'h00;
        reg_wr(TX_CONTROL_ADDR, ctrl);
        reg_wr(POWER_CTRL_ADDR, 8'h10);
        repeat (40) begin
            @(posedge ref_clk);
            check("pin powered down", serial_audio_out_pin, 1'b0);
            check("no sample while off", sampleTaken, 1'b0);
        end
        $display("test bypass and power done");
        // Sync mode: the audio tick paces the line, block restarts at power-up
        reg_wr(CLOCK_CFG_ADDR, 8'h10);
        started = 1'b0;
        reg_wr(POWER_CTRL_ADDR, 8'h00);
        repeat (6) sf_checked();
        $display("test sync mode done");
        // Hardware mode loads its own clocking and ignores writes
        hwMode <= 1'b1;
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        reg_wr(CLOCK_CFG_ADDR, 8'h00);
        reg_rd(CLOCK_CFG_ADDR, rdv);
        check("hw clock cfg", rdv, HW_CLOCK_CFG);
        check("hw rx enable", rxEnable, 1'b1);
        for (int r = 0; r < 4; r++) begin
            rxRateMode <= 2'(r);
            @(posedge ref_clk);
            #1 check("hw range", pll_freq_range_sel, rangeExp[r]);
            check("hw divider", pll_output_divider, 1'b0);
        end
        $display("test hardware mode done");
        test_done();
    end
endmodule
